// >>> verification/pwp_fw_model.sv
`timescale 1ns/1ns
module pwp_fw_model
   import pwp_pkg::*;
(
   // clock and request
   input  wire logic                  clk_i,
   input  wire logic                  req_i,
   // behaviour set by the bench
   input  wire logic [7:0]            delay_i,
   input  wire logic                  mute_i,
   input  wire logic [PWP_DATA_W-1:0] data_i,
   // answer
   output logic                       ack_o,
   output logic [PWP_CMD_W-1:0]       code_o,
   output logic [PWP_DATA_W-1:0]      data_o
);
   int cnt;
   initial
   begin
      ack_o  = 1'h0;
      code_o = 8'hA5;
      data_o = 32'h5A5A_5A5A;
      cnt    = 0;
   end
   // released code and data lines toggle every cycle, ack is held low
   always @(posedge clk_i)
   begin
      ack_o  <= 1'h0;
      code_o <= ~code_o;
      data_o <= ~data_o;
      if (req_i && !ack_o && !mute_i)
      begin
         if (cnt >= delay_i)
         begin
            ack_o  <= 1'h1;
            code_o <= PWP_CODE_OK;
            data_o <= data_i;
            cnt    <= 0;
         end
         else
            cnt <= cnt + 1;
      end
   end
endmodule : pwp_fw_model

// >>> verification/pwp_plane_ctl_props.sv
`timescale 1ns/1ns
module pwp_plane_ctl_props
   import pwp_pkg::*;
#(
   parameter int NPLANE      = 2,
   parameter int TIMEOUT_CYC = 20
)(
   input wire logic                              clk_i,
   input wire logic                              rst_b_i,
   input wire logic [NPLANE-1:0]                 prio_ctl_en_i,
   input wire logic [NPLANE-1:0]                 wm_wr_i,
   input wire logic [NPLANE-1:0]                 surf_base_wr_i,
   input wire logic [NPLANE-1:0][PWP_BLK_W-1:0] buf_alloc_i,
   input wire logic [NPLANE-1:0][PWP_BLK_W-1:0] fill_i,
   input wire logic [NPLANE-1:0]                 high_prio_o,
   input wire pwp_wm_s [NPLANE-1:0]              wm_level0_act_o,
   input wire pwp_wm_s [NPLANE-1:0]              wm_trans_act_o,
   input wire logic                              mb_wr_i,
   input wire pwp_mbox_s                         mb_req_i,
   input wire logic                              mb_busy_o,
   input wire logic [PWP_CMD_W-1:0]              mb_code_o,
   input wire logic [PWP_DATA_W-1:0]             mb_word_zero_o,
   input wire logic                              mb_timeout_o,
   input wire logic [PWP_CMD_W-1:0]              fw_cmd_o,
   input wire logic                              fw_ack_i,
   input wire logic [PWP_CMD_W-1:0]              fw_code_i,
   input wire logic [PWP_DATA_W-1:0]             fw_data_i
);
   localparam int BUSY_MAX = TIMEOUT_CYC + 3;
   logic [PWP_BLK_W-1:0] thr;
   logic [PWP_BLK_W-1:0] low;
   logic                 go;
   logic                 ok;
   assign thr = wm_trans_act_o[0].en ? wm_trans_act_o[0].blocks
                                     : buf_alloc_i[0];
   assign low = wm_level0_act_o[0].blocks;
   assign go  = mb_wr_i && mb_req_i.run && !mb_busy_o;
   assign ok  = mb_req_i.cmd == PWP_CMD_LATENCY
             || mb_req_i.cmd == PWP_CMD_BLKTIME;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence take_s;
      go && ok;
   endsequence
   sequence answer_s;
      fw_ack_i && mb_busy_o;
   endsequence
   busy_rise_a: assert property (take_s |=> mb_busy_o
      && fw_cmd_o == $past(mb_req_i.cmd)) else $error("busy not raised");
   bad_cmd_a: assert property (go && !ok |=> !mb_busy_o
      && mb_code_o == PWP_CODE_BADCMD) else $error("bad command kept");
   answer_copy_a: assert property (answer_s |=> !mb_busy_o
      && mb_code_o == $past(fw_code_i) && mb_word_zero_o == $past(fw_data_i))
      else $error("answer not passed on");
   busy_bound_a: assert property ($rose(mb_busy_o)
      |-> ##[1:BUSY_MAX] !mb_busy_o) else $error("busy too long");
   timeout_code_a: assert property ($rose(mb_timeout_o)
      |-> mb_code_o == PWP_CODE_NOFW && !mb_busy_o) else $error("bad timeout");
   prio_off_a: assert property (!prio_ctl_en_i[0] |=> high_prio_o[0])
      else $error("low priority with control off");
   prio_demote_a: assert property (prio_ctl_en_i[0]
      && high_prio_o[0] && fill_i[0] > thr |=> !high_prio_o[0])
      else $error("no demote");
   prio_promote_a: assert property (prio_ctl_en_i[0]
      && !high_prio_o[0] && fill_i[0] < low |=> high_prio_o[0])
      else $error("no promote");
   prio_hold_a: assert property (prio_ctl_en_i[0]
      && fill_i[0] <= thr && fill_i[0] >= low |=> $stable(high_prio_o[0]))
      else $error("flip");
   wm_pending_a: assert property (wm_wr_i[0] && !surf_base_wr_i[0]
      |=> $stable(wm_level0_act_o[0])) else $error("applied early");
endmodule : pwp_plane_ctl_props
bind pwp_plane_ctl pwp_plane_ctl_props #(.NPLANE(NPLANE),
   .TIMEOUT_CYC(TIMEOUT_CYC)) pwp_plane_ctl_props_inst (.clk_i, .rst_b_i,
   .prio_ctl_en_i, .wm_wr_i, .surf_base_wr_i, .buf_alloc_i, .fill_i,
   .high_prio_o, .wm_level0_act_o, .wm_trans_act_o, .mb_wr_i, .mb_req_i,
   .mb_busy_o, .mb_code_o, .mb_word_zero_o, .mb_timeout_o, .fw_cmd_o,
   .fw_ack_i, .fw_code_i, .fw_data_i);

// >>> verification/test_pwp_plane_ctl.sv
`timescale 1ns/1ns
`define CHK(n,e,g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_pwp_plane_ctl
   import pwp_pkg::*;
   ;
   logic clk_i, rst_b_i, ce_i, mb_wr_i, mb_busy_o, mb_timeout_o;
   logic mvs_wr_i, mvs_en_i, mvs_en_o, fw_req_o, fw_ack_i, fw_mute;
   logic [1:0] prio_ctl_en_i, wm_wr_i, surf_base_wr_i, high_prio_o, hp, ip;
   pwp_wm_s [1:0] wm_level0_i, wm_trans_i, wm_level0_act_o, wm_trans_act_o;
   logic [1:0][PWP_BLK_W-1:0] buf_alloc_i, fill_i, f;
   logic [PWP_BLK_W-1:0] l0, thr, t;
   pwp_mbox_s mb_req_i;
   logic [PWP_CMD_W-1:0] mb_code_o, fw_cmd_o, fw_code_i;
   logic [PWP_DATA_W-1:0] mb_word_zero_o, fw_word_zero_o, fw_data_i, fw_val;
   logic [PWP_DATA_W-1:0] lat_w;
   logic [7:0] fw_dly;
   int bad_count, samples_checked, k;
   pwp_plane_ctl #(.NPLANE(2), .TIMEOUT_CYC(20)) pwp_plane_ctl_inst (
      .clk_i, .rst_b_i, .ce_i, .prio_ctl_en_i, .wm_wr_i, .wm_level0_i,
      .wm_trans_i, .buf_alloc_i, .surf_base_wr_i, .fill_i, .high_prio_o,
      .wm_level0_act_o, .wm_trans_act_o, .mvs_wr_i, .mvs_en_i, .mvs_en_o,
      .mb_wr_i, .mb_req_i, .mb_busy_o, .mb_code_o, .mb_word_zero_o,
      .mb_timeout_o, .fw_req_o, .fw_cmd_o, .fw_word_zero_o, .fw_ack_i,
      .fw_code_i, .fw_data_i);
   pwp_fw_model pwp_fw_model_inst (.clk_i, .req_i(fw_req_o),
      .delay_i(fw_dly), .mute_i(fw_mute), .data_i(fw_val),
      .ack_o(fw_ack_i), .code_o(fw_code_i), .data_o(fw_data_i));
   initial
   begin
      clk_i = 1'h0;
      forever #20 clk_i = ~clk_i;
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   function automatic logic [PWP_BLK_W-1:0] l0_blocks(input logic [31:0] lat,
      input logic [31:0] blk, input int src, input int dst);
      int us, sc;
      us = int'(lat[7:0]);
      if (us == 0)
         us = us + 3;
      us = us + int'(blk[7:0]);
      sc = (src > dst) ? src / dst : 1;
      return 11'(10 + (us * sc) % 30);
   endfunction : l0_blocks
   task mbox(input logic [7:0] c, input logic [31:0] w,
             input logic [7:0] ec, input logic [31:0] ew, input bit cw);
      int n;
      @(posedge clk_i);
      mb_wr_i <= 1'h1;
      mb_req_i <= '{1'h1, c, w, 32'h0000_0000};
      @(posedge clk_i);
      mb_wr_i <= 1'h0;
      @(negedge clk_i);
      `CHK("busy", ec != PWP_CODE_BADCMD, mb_busy_o)
      `CHK("fw req", ec != PWP_CODE_BADCMD, fw_req_o)
      if (mb_busy_o === 1'h1)
      begin
         `CHK("fw cmd", c, fw_cmd_o)
         `CHK("fw word", w, fw_word_zero_o)
      end
      n = 0;
      while (mb_busy_o !== 1'h0 && n < 100)
      begin
         @(negedge clk_i);
         n++;
      end
      `CHK("code", ec, mb_code_o)
      if (cw) `CHK("word", ew, mb_word_zero_o)
      `CHK("timeout", ec == PWP_CODE_NOFW, mb_timeout_o)
      $display("test mailbox %0h done", c);
   endtask : mbox
   initial
   begin
      #(40 * 8000);
      bad_count++;
      give_verdict;
   end
   initial
   begin
      void'($urandom(90613));
      {rst_b_i, prio_ctl_en_i, wm_wr_i, surf_base_wr_i, mvs_wr_i, mb_wr_i} = '0;
      {wm_level0_i, wm_trans_i, fill_i, mb_req_i, fw_val, fw_dly} = '0;
      {ce_i, mvs_en_i, fw_mute} = 3'h6;
      buf_alloc_i = {11'h0C8, 11'h0C8};
      bad_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1'h1;
      @(negedge clk_i);
      `CHK("reset prio", 2'h3, high_prio_o)
      `CHK("reset mvs", 1'h1, mvs_en_o)
      @(posedge clk_i);
      mvs_wr_i <= 1'h1;
      mvs_en_i <= 1'h0;
      @(posedge clk_i);
      mvs_wr_i <= 1'h0;
      @(negedge clk_i);
      `CHK("mvs", 1'h0, mvs_en_o)
      @(posedge clk_i);
      ce_i <= 1'h0;
      mvs_wr_i <= 1'h1;
      mvs_en_i <= 1'h1;
      @(posedge clk_i);
      ce_i <= 1'h1;
      mvs_wr_i <= 1'h0;
      @(negedge clk_i);
      `CHK("frozen mvs", 1'h0, mvs_en_o)
      $display("test reset and scaling done");
      for (int i = 0; i < 3; i++)
      begin
         fw_dly = 8'(i * 6);
         fw_val = $urandom;
         if (i == 0 && fw_val[31])
            fw_val[7:0] = 8'h00;
         if (i == 0)
            lat_w = fw_val;
         mbox(i == 2 ? PWP_CMD_BLKTIME : PWP_CMD_LATENCY,
              i == 1 ? PWP_SET_HIGH : PWP_SET_LOW, PWP_CODE_OK, fw_val, 1);
      end
      mbox(8'h5A, PWP_ZERO_WORD, PWP_CODE_BADCMD, '0, 0);
      l0 = l0_blocks(lat_w, fw_val, $urandom_range(4000, 100),
                     $urandom_range(4000, 100));
      thr = l0 + 11'(4 + $urandom_range(20));
      @(posedge clk_i);
      wm_wr_i <= 2'h3;
      wm_level0_i <= {2{pwp_wm_s'{1'h1, 5'h02, l0}}};
      wm_trans_i <= {pwp_wm_s'{1'h0, 5'h1F, 11'h005},
                     pwp_wm_s'{1'h1, 5'h1F, thr}};
      @(posedge clk_i);
      wm_wr_i <= 2'h0;
      surf_base_wr_i <= 2'h3;
      @(negedge clk_i);
      `CHK("pending", 11'h000, wm_level0_act_o[0].blocks)
      @(posedge clk_i);
      surf_base_wr_i <= 2'h0;
      @(negedge clk_i);
      `CHK("active", l0, wm_level0_act_o[1].blocks)
      `CHK("trans off", 1'h0, wm_trans_act_o[1].en)
      $display("test watermark load done");
      hp = 2'h3;
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk_i);
         ip = (i % 50 < 3) ? 2'($urandom) : 2'h3;
         k = $urandom_range(6);
         for (int p = 0; p < 2; p++)
         begin
            t = p ? 11'h0C8 : thr;
            f[p] = k == 0 ? t : k == 1 ? t + 11'h001 : k == 2 ? l0 :
                   k == 3 ? l0 - 11'h001 : 11'($urandom_range(255));
            if (!ip[p])
               hp[p] = 1'h1;
            else if (hp[p] && f[p] > t)
               hp[p] = 1'h0;
            else if (!hp[p] && f[p] < l0)
               hp[p] = 1'h1;
         end
         fill_i <= f;
         prio_ctl_en_i <= ip;
         @(posedge clk_i);
         @(negedge clk_i);
         `CHK("prio", hp, high_prio_o)
      end
      $display("test priority done");
      fw_mute = 1'h1;
      mbox(PWP_CMD_LATENCY, PWP_SET_LOW, PWP_CODE_NOFW, '0, 0);
      give_verdict;
   end
endmodule : test_pwp_plane_ctl

// >>> verilog/pwp_mailbox.sv
`timescale 1ns/1ns
module pwp_mailbox
   import pwp_pkg::*;
#(
   parameter int TIMEOUT_CYC = PWP_TIMEOUT_CYC
)(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   input  wire logic                  ce_i,
   // software side
   input  wire logic                  mb_wr_i,
   input  wire pwp_mbox_s             mb_req_i,
   output logic                       mb_busy_o,
   output logic [PWP_CMD_W-1:0]       mb_code_o,
   output logic [PWP_DATA_W-1:0]      mb_word_zero_o,
   output logic                       mb_timeout_o,
   // firmware side
   output logic                       fw_req_o,
   output logic [PWP_CMD_W-1:0]       fw_cmd_o,
   output logic [PWP_DATA_W-1:0]      fw_word_zero_o,
   input  wire logic                  fw_ack_i,
   input  wire logic [PWP_CMD_W-1:0]  fw_code_i,
   input  wire logic [PWP_DATA_W-1:0] fw_data_i
);

   // -------------------------------------------------------------
   // mailbox state
   // -------------------------------------------------------------
   pwp_mb_state_e          st_reg, st_next;
   logic [PWP_CMD_W-1:0]   cmd_reg, cmd_next;
   logic [PWP_CMD_W-1:0]   code_reg, code_next;
   logic [PWP_DATA_W-1:0]  w0_reg, w0_next;
   logic [15:0]            tmr_reg, tmr_next;
   logic                   to_reg, to_next;

   function automatic logic known_cmd(input logic [PWP_CMD_W-1:0] c);
      known_cmd = (c == PWP_CMD_LATENCY) || (c == PWP_CMD_BLKTIME);
   endfunction : known_cmd

   always_comb
   begin
      st_next   = st_reg;
      cmd_next  = cmd_reg;
      code_next = code_reg;
      w0_next   = w0_reg;
      tmr_next  = tmr_reg;
      to_next   = to_reg;
      case (st_reg)
         PWP_MB_IDLE, PWP_MB_DONE:
         begin
            if (mb_wr_i && mb_req_i.run)
            begin
               cmd_next  = mb_req_i.cmd;
               w0_next   = mb_req_i.word0;
               code_next = mb_req_i.cmd;
               tmr_next  = '0;
               to_next   = 1'b0;
               if (known_cmd(mb_req_i.cmd))
                  st_next = PWP_MB_WAIT;
               else
               begin
                  code_next = PWP_CODE_BADCMD;
                  st_next   = PWP_MB_DONE;
               end
            end
         end
         PWP_MB_WAIT:
         begin
            if (fw_ack_i)
            begin
               code_next = fw_code_i;
               w0_next   = fw_data_i;
               st_next   = PWP_MB_DONE;
            end
            else if (tmr_reg == 16'(TIMEOUT_CYC - 1))
            begin
               code_next = PWP_CODE_NOFW;
               to_next   = 1'b1;
               st_next   = PWP_MB_DONE;
            end
            else
               tmr_next = tmr_reg + 16'h0001;
         end
         default:
            st_next = PWP_MB_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg   <= PWP_MB_IDLE;
         cmd_reg  <= '0;
         code_reg <= PWP_CODE_OK;
         w0_reg   <= '0;
         tmr_reg  <= '0;
         to_reg   <= 1'b0;
      end
      else if (ce_i)
      begin
         st_reg   <= st_next;
         cmd_reg  <= cmd_next;
         code_reg <= code_next;
         w0_reg   <= w0_next;
         tmr_reg  <= tmr_next;
         to_reg   <= to_next;
      end
   end

   assign mb_busy_o      = (st_reg == PWP_MB_WAIT);
   assign mb_code_o      = code_reg;
   assign mb_word_zero_o = w0_reg;
   assign mb_timeout_o   = to_reg;
   assign fw_req_o       = (st_reg == PWP_MB_WAIT);
   assign fw_cmd_o       = cmd_reg;
   assign fw_word_zero_o = w0_reg;

endmodule : pwp_mailbox

// >>> verilog/pwp_pkg.sv
package pwp_pkg;

   // -------------------------------------------------------------
   // widths
   // -------------------------------------------------------------
   localparam int PWP_BLK_W   = 11;
   localparam int PWP_LINE_W  = 5;
   localparam int PWP_DATA_W  = 32;
   localparam int PWP_CMD_W   = 8;
   localparam int PWP_LAT_W   = 8;
   localparam int PWP_NLVL    = 8;

   // -------------------------------------------------------------
   // mailbox codes
   // -------------------------------------------------------------
   localparam logic [7:0]  PWP_CMD_LATENCY = 8'h06;
   localparam logic [7:0]  PWP_CMD_BLKTIME = 8'h23;
   localparam logic [7:0]  PWP_CODE_OK     = 8'h00;
   localparam logic [7:0]  PWP_CODE_BADCMD = 8'h01;
   localparam logic [7:0]  PWP_CODE_NOFW   = 8'h02;
   localparam logic [31:0] PWP_SET_LOW     = 32'h0000_0000;
   localparam logic [31:0] PWP_SET_HIGH    = 32'h0000_0001;
   localparam logic [31:0] PWP_ZERO_WORD   = 32'h0000_0000;

   // -------------------------------------------------------------
   // priority levels and reset values
   // -------------------------------------------------------------
   localparam logic        PWP_PRIO_HIGH   = 1'h1;
   localparam logic        PWP_PRIO_LOW    = 1'h0;
   localparam logic        PWP_MVS_RESET   = 1'h1;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int PWP_CLK_MHZ        = 25;
   localparam int PWP_TIMEOUT_US     = 100;
   localparam int PWP_TIMEOUT_CYC    = PWP_TIMEOUT_US * PWP_CLK_MHZ;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic                  en;
      logic [PWP_LINE_W-1:0] lines;
      logic [PWP_BLK_W-1:0]  blocks;
   } pwp_wm_s;

   typedef struct packed {
      logic                  run;
      logic [PWP_CMD_W-1:0]  cmd;
      logic [PWP_DATA_W-1:0] word0;
      logic [PWP_DATA_W-1:0] word1;
   } pwp_mbox_s;

   typedef enum logic [1:0] {
      PWP_MB_IDLE = 2'b00,
      PWP_MB_WAIT = 2'b01,
      PWP_MB_DONE = 2'b10
   } pwp_mb_state_e;

endpackage : pwp_pkg

// >>> verilog/pwp_plane_ctl.sv
`timescale 1ns/1ns
module pwp_plane_ctl
   import pwp_pkg::*;
#(
   parameter int NPLANE      = 2,
   parameter int TIMEOUT_CYC = PWP_TIMEOUT_CYC
)(
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_b_i,
   input  wire logic                         ce_i,
   // plane configuration, pending copies
   input  wire logic [NPLANE-1:0]            prio_ctl_en_i,
   input  wire logic [NPLANE-1:0]            wm_wr_i,
   input  wire pwp_wm_s [NPLANE-1:0]         wm_level0_i,
   input  wire pwp_wm_s [NPLANE-1:0]         wm_trans_i,
   input  wire logic [NPLANE-1:0][PWP_BLK_W-1:0] buf_alloc_i,
   input  wire logic [NPLANE-1:0]            surf_base_wr_i,
   // plane fetch status
   input  wire logic [NPLANE-1:0][PWP_BLK_W-1:0] fill_i,
   output logic [NPLANE-1:0]                 high_prio_o,
   output pwp_wm_s [NPLANE-1:0]              wm_level0_act_o,
   output pwp_wm_s [NPLANE-1:0]              wm_trans_act_o,
   // memory voltage scaling
   input  wire logic                         mvs_wr_i,
   input  wire logic                         mvs_en_i,
   output logic                              mvs_en_o,
   // firmware_command_mailbox, software side
   input  wire logic                         mb_wr_i,
   input  wire pwp_mbox_s                    mb_req_i,
   output logic                              mb_busy_o,
   output logic [PWP_CMD_W-1:0]              mb_code_o,
   output logic [PWP_DATA_W-1:0]             mb_word_zero_o,
   output logic                              mb_timeout_o,
   // firmware side
   output logic                              fw_req_o,
   output logic [PWP_CMD_W-1:0]              fw_cmd_o,
   output logic [PWP_DATA_W-1:0]             fw_word_zero_o,
   input  wire logic                         fw_ack_i,
   input  wire logic [PWP_CMD_W-1:0]         fw_code_i,
   input  wire logic [PWP_DATA_W-1:0]        fw_data_i
);

   // -------------------------------------------------------------
   // voltage scaling enable
   // -------------------------------------------------------------
   logic mvs_reg, mvs_next;

   always_comb
   begin
      mvs_next = mvs_reg;
      if (mvs_wr_i)
         mvs_next = mvs_en_i;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         mvs_reg <= PWP_MVS_RESET;
      else if (ce_i)
         mvs_reg <= mvs_next;
   end

   assign mvs_en_o = mvs_reg;

   // -------------------------------------------------------------
   // transition threshold
   // -------------------------------------------------------------
   // transition lines are never looked at
   function automatic logic [PWP_BLK_W-1:0] trans_level
   (
      input pwp_wm_s              tr,
      input logic [PWP_BLK_W-1:0] top
   );
      trans_level = tr.en ? tr.blocks : top;
   endfunction : trans_level

   // -------------------------------------------------------------
   // priority decision
   // -------------------------------------------------------------
   function automatic logic next_prio
   (
      input logic                 ctl_en,
      input logic                 cur,
      input logic [PWP_BLK_W-1:0] fill,
      input logic [PWP_BLK_W-1:0] hi_thr,
      input logic [PWP_BLK_W-1:0] lo_thr
   );
      next_prio = cur;
      if (!ctl_en)
         next_prio = PWP_PRIO_HIGH;
      else if (cur && (fill > hi_thr))
         next_prio = PWP_PRIO_LOW;
      else if (!cur && (fill < lo_thr))
         next_prio = PWP_PRIO_HIGH;
   endfunction : next_prio

   // -------------------------------------------------------------
   // per-plane watermark and priority
   // -------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NPLANE; p++)
      begin : g_plane
         pwp_wm_s pend_l0_reg, pend_l0_next;
         pwp_wm_s pend_tr_reg, pend_tr_next;
         pwp_wm_s act_l0_reg, act_l0_next;
         pwp_wm_s act_tr_reg, act_tr_next;

         logic    prio_reg, prio_next;
         logic [PWP_BLK_W-1:0] tr_thr;
         logic [PWP_BLK_W-1:0] l0_thr;

         // -------------------------------------------------------
         // pending and active watermarks
         // -------------------------------------------------------
         always_comb
         begin
            pend_l0_next = pend_l0_reg;
            pend_tr_next = pend_tr_reg;
            act_l0_next  = act_l0_reg;
            act_tr_next  = act_tr_reg;
            if (wm_wr_i[p])
            begin
               pend_l0_next = wm_level0_i[p];
               pend_tr_next = wm_trans_i[p];
            end
            if (surf_base_wr_i[p])
            begin
               act_l0_next = wm_wr_i[p] ? wm_level0_i[p] : pend_l0_reg;
               act_tr_next = wm_wr_i[p] ? wm_trans_i[p] : pend_tr_reg;
            end
         end

         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               pend_l0_reg <= '0;
               pend_tr_reg <= '0;
               act_l0_reg  <= '0;
               act_tr_reg  <= '0;
            end
            else if (ce_i)
            begin
               pend_l0_reg <= pend_l0_next;
               pend_tr_reg <= pend_tr_next;
               act_l0_reg  <= act_l0_next;
               act_tr_reg  <= act_tr_next;
            end
         end

         // -------------------------------------------------------
         // request priority
         // -------------------------------------------------------
         assign tr_thr = trans_level(act_tr_reg, buf_alloc_i[p]);
         assign l0_thr = act_l0_reg.blocks;

         always_comb
         begin
            prio_next = next_prio(prio_ctl_en_i[p], prio_reg, fill_i[p],
                                  tr_thr, l0_thr);
         end

         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               prio_reg <= PWP_PRIO_HIGH;
            else if (ce_i)
               prio_reg <= prio_next;
         end

         assign high_prio_o[p]     = prio_reg;
         assign wm_level0_act_o[p] = act_l0_reg;
         assign wm_trans_act_o[p]  = act_tr_reg;
      end
   endgenerate

   // -------------------------------------------------------------
   // firmware command mailbox
   // -------------------------------------------------------------
   pwp_mailbox #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_mailbox (
      .clk_i          (clk_i),
      .rst_b_i        (rst_b_i),
      .ce_i           (ce_i),
      .mb_wr_i        (mb_wr_i),
      .mb_req_i       (mb_req_i),
      .mb_busy_o      (mb_busy_o),
      .mb_code_o      (mb_code_o),
      .mb_word_zero_o (mb_word_zero_o),
      .mb_timeout_o   (mb_timeout_o),
      .fw_req_o       (fw_req_o),
      .fw_cmd_o       (fw_cmd_o),
      .fw_word_zero_o (fw_word_zero_o),
      .fw_ack_i       (fw_ack_i),
      .fw_code_i      (fw_code_i),
      .fw_data_i      (fw_data_i)
   );

endmodule : pwp_plane_ctl
